// [design/sfw_pkg.sv]
// Shared constants and types for the serial flash write-enable/status block.
// Assumes a 250 MHz system clock; all link pins are sampled by that clock.
package sfw_pkg;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
    localparam logic [7:0] OP_VOL_UNLOCK = 8'h50;
    localparam logic [7:0] OP_STATUS_READ_LO = 8'h05;
    localparam logic [7:0] OP_STATUS_READ_HI = 8'h35;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_STATUS_HIGH_WRITE = 8'h31;

    // ----------------------------------------------------------------
    // Frame lengths in link bits, opcode included
    // ----------------------------------------------------------------
    localparam logic [4:0] BITS_OPCODE = 5'h08;
    localparam logic [4:0] BITS_ONE_BYTE = 5'h10;
    localparam logic [4:0] BITS_TWO_BYTES = 5'h18;
    localparam logic [4:0] BITS_SAT = 5'h1f;

    // ----------------------------------------------------------------
    // Status register layout, bit 15 down to bit 0
    // ----------------------------------------------------------------
    typedef struct packed {
        logic paused_flag;
        logic protect_invert;
        logic [2:0] otp_lock;
        logic dummy_select;
        logic quad_pins_enable;
        logic status_guard_hi;
        logic status_guard_lo;
        logic [4:0] area_guard;
        logic write_enable_latch;
        logic busy_flag;
    } sfw_status_t;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [1:0] GUARD_SOFT = 2'h0;
    localparam logic [1:0] GUARD_PIN = 2'h1;
    localparam logic [1:0] GUARD_POWER = 2'h2;

    // ----------------------------------------------------------------
    // Dummy clocks for the 2-line and 4-line address reads
    // ----------------------------------------------------------------
    localparam logic [3:0] DUMMY_2IO_DC0 = 4'h4;
    localparam logic [3:0] DUMMY_2IO_DC1 = 4'h8;
    localparam logic [3:0] DUMMY_4IO_DC0 = 4'h6;
    localparam logic [3:0] DUMMY_4IO_DC1 = 4'ha;

    // ----------------------------------------------------------------
    // Security area address fields
    // ----------------------------------------------------------------
    localparam logic [7:0] SEC_UPPER = 8'h00;
    localparam logic [2:0] SEC_GAP = 3'h0;
    localparam logic [3:0] SEC_AREA_1 = 4'h1;
    localparam logic [3:0] SEC_AREA_3 = 4'h3;

    // ----------------------------------------------------------------
    // Self-timed status write cycle
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned STATUS_WRITE_NS = 8000;
    localparam int unsigned STATUS_WRITE_CYC = (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : sfw_pkg

// [design/sfw_sync.sv]
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is a slow level; no multi-bit coherence is promised.
module sfw_sync #(
    parameter int unsigned WIDTH = 6
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            meta_q <= rst_val_i;
            sync_q <= rst_val_i;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // sfw_sync

// [design/sfw_busy_timer.sv]
// Self-timed cycle counter for the non-volatile status write.
// Assumes start only arrives while idle; a start while busy is ignored.
module sfw_busy_timer #(
    parameter int unsigned CYCLES = 2000,
    parameter int unsigned CW = $clog2(CYCLES + 1)
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic done_q;
    logic done_d;

    // Count down; done pulses the cycle after the last busy cycle
    always_comb begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
            done_d = (cnt_q == CW'(1));
        end else if (start_i) begin
            cnt_d = CW'(CYCLES);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy_o = (cnt_q != '0);
    assign done_o = done_q;
endmodule // sfw_busy_timer

// [design/sfw_top.sv]
// Write-enable latch and status register logic of a serial NOR flash.
// Assumes the link pins are asynchronous and slow against clk_sys_i.
// Overview of operation
// - Write-unlock opcode sets the write enable latch.
// - Unlock, lock and volatile-unlock frames are exactly one opcode byte.
// - Write-lock opcode clears the write enable latch.
// - Latch clears at power-up, on write completion, soft reset, volatile-unlock.
// - Volatile-unlock sets neither latch nor lock bits; arms next status write.
// - Status reads are accepted at any time, even while busy.
// - Opcode 05h returns bits 7..0, 35h returns bits 15..8.
// - Status layout fixed, every bit resets to zero.
// - Paused and busy read-only, latch volatile, lock bits one-time.
// - Busy flag is one exactly while a write operation runs.
// - With the latch clear and no volatile-unlock armed, status writes, programs and erases are refused.
// - Area guard selects protected region; written only outside hardware lock.
// - Whole-array erase allowed only when no region is guarded.
// - Status guard modes: free, pin-gated, locked until power cycle, permanent.
// - Guard mode 10 is left only by power cycle, not soft reset.
// - Quad enable turns guard and pause pins into data lines.
// - Dummy select picks 4 or 8 clocks for 2-line, 6 or 10 for 4-line.
// - Quad command mode moves four bits per clock, high nibble first.
// - Security areas 1..3 use fixed upper address fields, byte in A8..A0.
// - Status write runs only if frame ends after 8 or 16 data bits.
// - Status write data never reaches paused, latch and busy bits; a non-volatile write clears the latch at its end.
// - A lock bit once set stays set; its area becomes read-only.
module sfw_top import sfw_pkg::*; #(
    parameter int unsigned TW_CYCLES = STATUS_WRITE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic [3:0] sio_i,
    input wire logic qpi_mode_i,
    input wire logic op_busy_i,
    input wire logic op_done_i,
    input wire logic pause_set_i,
    input wire logic pause_clr_i,
    input wire logic soft_reset_i,
    input wire logic [23:0] probe_addr_i,
    output logic [3:0] sio_o,
    output logic [3:0] sio_oe_o,
    output logic [15:0] status_o,
    output logic write_unlocked_o,
    output logic full_clear_ok_o,
    output logic quad_pins_o,
    output logic guard_pin_active_o,
    output logic pause_pin_active_o,
    output logic [3:0] dummy_2io_o,
    output logic [3:0] dummy_4io_o,
    output logic probe_read_only_o
);
    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Security area index from an address, zero when none
    function automatic logic [1:0] sec_area(input logic [23:0] a);
        sec_area = 2'h0;
        if (a[23:16] == SEC_UPPER && a[11:9] == SEC_GAP && a[15:12] >= SEC_AREA_1
            && a[15:12] <= SEC_AREA_3) begin
            sec_area = a[13:12];
        end
    endfunction

    // Status write permitted by the guard mode and the guard pin
    function automatic logic guard_allows(input logic [1:0] g, input logic pin);
        guard_allows = (g == GUARD_SOFT) || (g == GUARD_PIN && pin);
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [5:0] pins_s;
    logic sclk_s;
    logic cs_n_s;
    logic [3:0] sio_s;

    sfw_sync #(.WIDTH(6)) u_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i({sclk_i, cs_n_i, sio_i}),
        .rst_val_i(6'h10),
        .sync_o(pins_s)
    );
    assign sclk_s = pins_s[5];
    assign cs_n_s = pins_s[4];
    assign sio_s = pins_s[3:0];

    // ----------------------------------------------------------------
    // Edge detection on the synchronised pins
    // ----------------------------------------------------------------
    logic sclk_prev_q;
    logic cs_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_n_s;
        end
    end
    assign sclk_rise = sclk_s && !sclk_prev_q && !cs_n_s;
    assign sclk_fall = !sclk_s && sclk_prev_q && !cs_n_s;
    assign cs_fall = !cs_n_s && cs_prev_q;
    assign cs_rise = cs_n_s && !cs_prev_q;

    // ----------------------------------------------------------------
    // Self-timed status write cycle
    // ----------------------------------------------------------------
    logic sw_start;
    logic tmr_busy;
    logic tmr_done;

    sfw_busy_timer #(.CYCLES(TW_CYCLES)) u_timer (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .start_i(sw_start),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    // ----------------------------------------------------------------
    // Link frame decoder and status register
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_CMD, ST_READ, ST_WRDATA} sfw_state_t;

    sfw_state_t state_q, state_d;
    logic [4:0] bits_q, bits_d;
    logic [23:0] shin_q, shin_d;
    logic [7:0] opcode_q, opcode_d;
    logic [7:0] shout_q, shout_d;
    logic [2:0] outcnt_q, outcnt_d;
    logic [3:0] sio_q, sio_d;
    logic [3:0] oe_q, oe_d;
    sfw_status_t st_q, st_d;
    sfw_status_t pend_q, pend_d;
    logic vol_armed_q, vol_armed_d;
    logic exec_unlock;
    logic exec_lock;
    logic exec_vol;
    logic sw_accept;
    logic sw_vol_apply;
    logic [7:0] cur_byte;
    logic [7:0] out_byte;
    logic [2:0] step;
    logic guard_pin;

    // Guard pin only has its control meaning while quad pins are off
    assign guard_pin = st_q.quad_pins_enable ? 1'b1 : sio_s[2];
    assign step = qpi_mode_i ? 3'h4 : 3'h1;

    always_comb begin
        state_d = state_q;
        bits_d = bits_q;
        shin_d = shin_q;
        opcode_d = opcode_q;
        shout_d = shout_q;
        outcnt_d = outcnt_q;
        sio_d = sio_q;
        oe_d = oe_q;
        st_d = st_q;
        pend_d = pend_q;
        vol_armed_d = vol_armed_q;
        exec_unlock = 1'b0;
        exec_lock = 1'b0;
        exec_vol = 1'b0;
        sw_accept = 1'b0;
        sw_vol_apply = 1'b0;
        sw_start = 1'b0;
        out_byte = 8'h00;
        // Status byte chosen by the read opcode
        cur_byte = (opcode_q == OP_STATUS_READ_HI) ? st_q[15:8] : st_q[7:0];

        if (cs_fall) begin
            state_d = ST_OPCODE;
            bits_d = 5'h00;
            shin_d = 24'h000000;
        end else if (sclk_rise && state_q != ST_IDLE) begin
            // Single line samples IO0, quad mode takes a nibble, MSB first
            if (qpi_mode_i) begin
                shin_d = {shin_q[19:0], sio_s};
            end else begin
                shin_d = {shin_q[22:0], sio_s[0]};
            end
            bits_d = (bits_q > 5'h1b) ? BITS_SAT : bits_q + 5'(step);
            if (state_q == ST_OPCODE && bits_d == BITS_OPCODE) begin
                opcode_d = shin_d[7:0];
                outcnt_d = 3'h0;
                // Reads are served even while busy
                if (opcode_d == OP_STATUS_READ_LO || opcode_d == OP_STATUS_READ_HI) begin
                    state_d = ST_READ;
                end else if (opcode_d == OP_STATUS_WRITE || opcode_d == OP_STATUS_HIGH_WRITE) begin
                    state_d = ST_WRDATA;
                end else begin
                    state_d = ST_CMD;
                end
            end
        end else if (sclk_fall && state_q == ST_READ) begin
            // Reload at each byte boundary so polling sees a live busy flag
            out_byte = (outcnt_q == 3'h0) ? cur_byte : shout_q;
            if (qpi_mode_i) begin
                sio_d = out_byte[7:4];
                oe_d = 4'hf;
            end else begin
                sio_d = {2'h0, out_byte[7], 1'b0};
                oe_d = 4'h2;
            end
            shout_d = out_byte << step;
            outcnt_d = outcnt_q + step;
        end

        if (cs_rise) begin
            state_d = ST_IDLE;
            oe_d = 4'h0;
            vol_armed_d = 1'b0;
            // One-byte frames only; extra clocks void the command
            if (state_q == ST_CMD && bits_q == BITS_OPCODE) begin
                exec_unlock = (opcode_q == OP_WRITE_UNLOCK);
                exec_lock = (opcode_q == OP_WRITE_LOCK);
                exec_vol = (opcode_q == OP_VOL_UNLOCK);
                vol_armed_d = exec_vol;
            end
            if (state_q == ST_WRDATA) begin
                sw_accept = ((bits_q == BITS_ONE_BYTE)
                    || (bits_q == BITS_TWO_BYTES && opcode_q == OP_STATUS_WRITE))
                    && (st_q.write_enable_latch || vol_armed_q)
                    && guard_allows({st_q.status_guard_hi, st_q.status_guard_lo}, guard_pin)
                    && !tmr_busy;
            end
        end

        // Merge written bytes; paused, latch and busy keep their values
        if (sw_accept) begin
            pend_d = st_q;
            if (opcode_q == OP_STATUS_HIGH_WRITE) begin
                pend_d[14:8] = shin_q[6:0];
            end else if (bits_q == BITS_TWO_BYTES) begin
                pend_d[7:2] = shin_q[15:10];
                pend_d[14:8] = shin_q[6:0];
            end else begin
                pend_d[7:2] = shin_q[7:2];
            end
            // Lock bits only ever gain ones, and not from a volatile write
            pend_d.otp_lock = vol_armed_q ? st_q.otp_lock
                : (st_q.otp_lock | pend_d.otp_lock);
            sw_vol_apply = vol_armed_q;
            sw_start = !vol_armed_q;
        end

        // Apply volatile write now, non-volatile one at cycle end
        if (sw_vol_apply || tmr_done) begin
            st_d[14:2] = sw_vol_apply ? pend_d[14:2] : pend_q[14:2];
        end

        // Latch: clears first, the set wins a same-cycle clash
        if (exec_lock || exec_vol || op_done_i || tmr_done || soft_reset_i) begin
            st_d.write_enable_latch = 1'b0;
        end
        if (exec_unlock) begin
            st_d.write_enable_latch = 1'b1;
        end

        // Paused flag, set wins over clear
        if (pause_clr_i || soft_reset_i) begin
            st_d.paused_flag = 1'b0;
        end
        if (pause_set_i) begin
            st_d.paused_flag = 1'b1;
        end
        if (soft_reset_i) begin
            vol_armed_d = 1'b0;
        end
        st_d.busy_flag = tmr_busy || op_busy_i || sw_start;
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
            bits_q <= 5'h00;
            shin_q <= 24'h000000;
            opcode_q <= 8'h00;
            shout_q <= 8'h00;
            outcnt_q <= 3'h0;
            sio_q <= 4'h0;
            oe_q <= 4'h0;
            st_q <= STATUS_RST;
            pend_q <= STATUS_RST;
            vol_armed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bits_q <= bits_d;
            shin_q <= shin_d;
            opcode_q <= opcode_d;
            shout_q <= shout_d;
            outcnt_q <= outcnt_d;
            sio_q <= sio_d;
            oe_q <= oe_d;
            st_q <= st_d;
            pend_q <= pend_d;
            vol_armed_q <= vol_armed_d;
        end
    end

    // ----------------------------------------------------------------
    // Registered side outputs
    // ----------------------------------------------------------------
    logic clear_ok_q, clear_ok_d;
    logic guard_act_q, guard_act_d;
    logic pause_act_q, pause_act_d;
    logic [3:0] d2_q, d2_d;
    logic [3:0] d4_q, d4_d;
    logic ro_q, ro_d;
    logic [1:0] area;

    // One cycle behind the status flops, traded for clean outputs
    always_comb begin
        area = sec_area(probe_addr_i);
        clear_ok_d = st_q.write_enable_latch && (st_q.area_guard == 5'h00);
        guard_act_d = !st_q.quad_pins_enable && !sio_s[2];
        pause_act_d = !st_q.quad_pins_enable && !sio_s[3];
        d2_d = st_q.dummy_select ? DUMMY_2IO_DC1 : DUMMY_2IO_DC0;
        d4_d = st_q.dummy_select ? DUMMY_4IO_DC1 : DUMMY_4IO_DC0;
        ro_d = (area != 2'h0) && st_q.otp_lock[2'(area - 2'h1)];
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            clear_ok_q <= 1'b0;
            guard_act_q <= 1'b0;
            pause_act_q <= 1'b0;
            d2_q <= DUMMY_2IO_DC0;
            d4_q <= DUMMY_4IO_DC0;
            ro_q <= 1'b0;
        end else begin
            clear_ok_q <= clear_ok_d;
            guard_act_q <= guard_act_d;
            pause_act_q <= pause_act_d;
            d2_q <= d2_d;
            d4_q <= d4_d;
            ro_q <= ro_d;
        end
    end

    assign sio_o = sio_q;
    assign sio_oe_o = oe_q;
    assign status_o = st_q;
    assign write_unlocked_o = st_q.write_enable_latch;
    assign full_clear_ok_o = clear_ok_q;
    assign quad_pins_o = st_q.quad_pins_enable;
    assign guard_pin_active_o = guard_act_q;
    assign pause_pin_active_o = pause_act_q;
    assign dummy_2io_o = d2_q;
    assign dummy_4io_o = d4_q;
    assign probe_read_only_o = ro_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    property p_unlock_sets;
        exec_unlock |=> st_q.write_enable_latch;
    endproperty
    a_unlock_sets: assert property (p_unlock_sets) else $error("latch not set");

    property p_lock_clears;
        exec_lock |=> !st_q.write_enable_latch;
    endproperty
    a_lock_clears: assert property (p_lock_clears) else $error("latch not cleared");

    property p_done_clears;
        (tmr_done && !exec_unlock) |=> !st_q.write_enable_latch && !st_q.busy_flag[*1];
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("latch kept after write");

    property p_vol_no_latch;
        exec_vol |=> !st_q.write_enable_latch && $stable(st_q.otp_lock);
    endproperty
    a_vol_no_latch: assert property (p_vol_no_latch) else $error("volatile unlock side effect");

    property p_busy_follows;
        (sw_start || op_busy_i) |=> st_q.busy_flag;
    endproperty
    a_busy_follows: assert property (p_busy_follows) else $error("busy flag low");

    property p_reject_locked;
        sw_start |-> st_q.write_enable_latch;
    endproperty
    a_reject_locked: assert property (p_reject_locked) else $error("write without latch");

    property p_frame_length;
        sw_accept |-> (bits_q == BITS_ONE_BYTE || bits_q == BITS_TWO_BYTES);
    endproperty
    a_frame_length: assert property (p_frame_length) else $error("bad write length");

    property p_otp_sticky;
        ($past(st_q.otp_lock) & ~st_q.otp_lock) == 3'h0;
    endproperty
    a_otp_sticky: assert property (p_otp_sticky) else $error("lock bit cleared");

    property p_power_lock;
        (st_q.status_guard_hi && !st_q.status_guard_lo) |=> st_q.status_guard_hi;
    endproperty
    a_power_lock: assert property (p_power_lock) else $error("guard mode left");

    property p_clear_ok;
        full_clear_ok_o |-> $past(st_q.area_guard) == 5'h00;
    endproperty
    a_clear_ok: assert property (p_clear_ok) else $error("whole erase while guarded");

    property p_dummy;
        ##1 dummy_2io_o == ($past(st_q.dummy_select) ? 4'h8 : 4'h4);
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy count wrong");

    c_unlock: cover property (exec_unlock);
    c_read_busy: cover property (state_q == ST_READ && st_q.busy_flag && sclk_fall);
    c_nv_write: cover property (tmr_busy ##1 tmr_done);
    c_vol_write: cover property (sw_vol_apply);

endmodule // sfw_top

// [test/sfw_host_model.sv]
// Host model for the serial link: frames bits, samples the reply.
// Assumes clk_sys_i at 250 MHz; half an sclk period is 8 cycles.
module sfw_host_model (
    input wire logic clk_sys_i,
    input wire logic [3:0] sio_o,
    input wire logic [3:0] sio_oe_i,
    output logic sclk_o = 1'b0,
    output logic cs_n_o = 1'b1,
    output logic [3:0] sio_drv_o = 4'hf
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic half();
        repeat (8) @(posedge clk_sys_i);
        #1;
    endtask
    // Frame of n clocks; quad sends nibbles; rd keeps the last 8 bits read
    task automatic frame(input logic [23:0] d, input int n, input logic q,
        output logic [7:0] rd);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            sio_drv_o = q ? d[23:20] : {3'b111, d[23]};
            d = q ? d << 4 : d << 1;
            half();
            rd = {rd[6:0], sio_oe_i[1] ? sio_o[1] : 1'b1}; // Undriven line idles high
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        // Freed data lines flip; guard and pause pins stay held high in single mode
        sio_drv_o = q ? ~sio_drv_o : {3'b111, ~sio_drv_o[0]};
        half();
    endtask
endmodule // sfw_host_model

// [test/test_sfw_top.sv]
// Bench for sfw_top: random status data with hand-picked corner frames.
// Assumes sfw_host_model drives the link pins; status write is shortened.
module test_sfw_top import sfw_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, quad_command_mode = 1'b0, srst = 1'b0;
    logic obusy = 1'b0, odone = 1'b0, pset = 1'b0;
    logic sclk, cs_n, wl, fc, qp, ro, ga, pa;
    logic [3:0] sio, sio_o, oe, d2, d4;
    logic [15:0] st;
    logic [7:0] rd, d;
    int bad_count = 0, checks = 0;
    // Free-running system clock
    always #2 clk_sys_i = ~clk_sys_i;
    sfw_host_model host (.clk_sys_i(clk_sys_i), .sio_o(sio_o), .sio_oe_i(oe), .sclk_o(sclk),
        .cs_n_o(cs_n), .sio_drv_o(sio));
    // Write cycle outlasts a read frame, so busy can be read back
    sfw_top #(.TW_CYCLES(400)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .sio_i(sio), .qpi_mode_i(quad_command_mode), .op_busy_i(obusy),
        .op_done_i(odone), .pause_set_i(pset), .pause_clr_i(1'b0), .soft_reset_i(srst),
        .probe_addr_i(24'h002155), .sio_o(sio_o), .sio_oe_o(oe), .status_o(st),
        .write_unlocked_o(wl), .full_clear_ok_o(fc), .quad_pins_o(qp),
        .guard_pin_active_o(ga), .pause_pin_active_o(pa), .dummy_2io_o(d2),
        .dummy_4io_o(d4), .probe_read_only_o(ro));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tx(input logic [7:0] c, input logic [15:0] v, input int n);
        host.frame({c, v}, n, 1'b0, rd);
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 1000 && st[0] !== 1'b0; k++) #4;
        bad_count += int'(k == 1000);
        if (k == 1000) end_of_test();
        #8;
    endtask
    // Main sequence; inputs move 1 ns after a rising edge
    initial begin
        void'($urandom(32'hab849ae4));
        #79 sys_rst_i = 1'b0;
        #16;
        chk(st, STATUS_RST, "reset");
        tx(OP_WRITE_UNLOCK, 16'h0, 8);
        chk({fc, st[14:0]}, 16'h8002, "unlock");
        tx(OP_STATUS_READ_LO, 16'h0, 16);
        chk({8'h0, rd}, 16'h0002, "read low");
        // Array engine: busy shows a cycle later, its completion drops the latch
        obusy = 1'b1;
        #4 obusy = 1'b0;
        odone = 1'b1;
        chk(st, 16'h0003, "engine busy");
        #4 odone = 1'b0;
        chk(st, 16'h0000, "engine done");
        tx(OP_WRITE_LOCK, 16'h0, 8);
        tx(OP_WRITE_UNLOCK, 16'h0, 16);
        chk(st, 16'h0, "lock");
        $display("test latch done");
        d = 8'($urandom) & 8'h7c | 8'h04;
        tx(OP_STATUS_WRITE, {d, 8'h0}, 16);
        chk(st, 16'h0, "no latch");
        tx(OP_WRITE_UNLOCK, 16'h0, 8);
        tx(OP_STATUS_WRITE, {d, 8'h0}, 16);
        tx(OP_STATUS_READ_LO, 16'h0, 16);
        // New bits land only when the write cycle ends; latch and busy still up
        chk({8'h0, rd}, 16'h0003, "read busy");
        wait_idle();
        chk(st, {8'h0, d}, "write done");
        tx(OP_VOL_UNLOCK, 16'h0, 8);
        tx(OP_STATUS_WRITE, 16'h000e, 24);
        chk(st, 16'h0600, "volatile");
        chk({d2, d4, 7'h0, qp}, {DUMMY_2IO_DC1, DUMMY_4IO_DC1, 8'h01}, "dummy");
        tx(OP_WRITE_UNLOCK, 16'h0, 8);
        tx(OP_STATUS_HIGH_WRITE, 16'h1000, 16);
        wait_idle();
        chk({11'h0, st[15:11]}, 16'h0002, "lock bit");
        chk({15'h0, ro}, 16'h0001, "area");
        $display("test write done");
        tx(OP_VOL_UNLOCK, 16'h0, 8);
        tx(OP_STATUS_WRITE, 16'h0001, 24);
        tx(OP_WRITE_UNLOCK, 16'h0, 8);
        tx(OP_STATUS_WRITE, 16'h7c00, 16);
        pset = 1'b1;
        #4 pset = 1'b0;
        chk({st[15], st[8:0], 6'h0}, 16'hc080, "guarded");
        srst = 1'b1;
        #4 srst = 1'b0;
        #16;
        chk({st[15], st[8:0], 6'h0}, 16'h4000, "soft reset");
        $display("test guard done");
        quad_command_mode = 1'b1;
        host.frame({OP_WRITE_UNLOCK, 16'h0}, 2, 1'b1, rd);
        chk({15'h0, wl}, 16'h0001, "quad unlock");
        chk({14'h0, ga, pa}, 16'h0002, "guard pin");
        $display("test quad done");
        end_of_test();
    end
endmodule // test_sfw_top
